// [core/ees_defs.vh]
// Constants for the two-wire serial memory slave front end.
// Assumes a 100 MHz system clock and a Wishbone classic register port.
`ifndef EES_DEFS_VH
`define EES_DEFS_VH

// ****************************************************************
// Protocol constants
// ****************************************************************
`define EES_DEV_CODE 4'h6 // Arbitrary device-type code
`define EES_CTRL_HI 7
`define EES_CTRL_LO 4
`define EES_RW_BIT 0
`define EES_PAGE_BITS 3
`define EES_ADDR_BITS 7

// ****************************************************************
// Timing
// ****************************************************************
`define EES_CLK_MHZ 100
`define EES_TWC_US 5000
`define EES_TWC_CYCLES 20'd500000 // 5000 us at 100 MHz, sized for the timer

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define EES_REG_CTRL 8'h00
`define EES_REG_STAT 8'h04
`define EES_REG_WCNT 8'h08
`define EES_CTRL_SWP 0
`define EES_CTRL_RST 32'h00000000
`define EES_STAT_BUSY 0
`define EES_STAT_PEND 1
`define EES_STAT_ACT 2
`define EES_STAT_WP 3
`define EES_STAT_PTR_LO 8

`endif

// [core/ees_i2c_slave.v]
// Two-wire bus slave of a 128 x 8 serial memory, with Wishbone status port.
// Assumes scl_i, sda_i and wp_i come from pins, outside the clock domain,
// and that the sda wire is resolved outside from sda_o and sda_oe_o.
`timescale 1ns/10ps
`default_nettype none
`include "ees_defs.vh"

// Operation
// R1: Upper four control bits must match code
// R2: Block-select bits are ignored entirely
// R3: Control bit zero selects read or write
// R4: Acknowledge matching control byte unless busy
// R5: Word-address byte loads pointer, acknowledged
// R6: Stop after data launches timed write
// R7: No acknowledges while write cycle runs
// R8: Up to eight bytes buffered until Stop
// R9: Page write increments low pointer bits only
// R10: Master must not cross page boundary
// R11: Write-protect blocks writes, reads still work
// R12: Current read uses last address plus one
// R13: Read byte shifted out after acknowledge
// R14: Repeated Start keeps pointer, drops write
// R15: Master acknowledge continues with next byte
// R16: Pointer increments after every byte
// R17: Data changes only while clock low
// R18: Start and Stop framed by clock high
// R19: Write cycle ends within five milliseconds
// R20: No master acknowledge releases data line
// R21: Seven-bit pointer wraps, top bit ignored
// R22: Mismatch ignores bus until next Start
module ees_i2c_slave #(
    parameter [19:0] TWC_CYCLES = `EES_TWC_CYCLES
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg wb_ack_o,
    output reg [31:0] wb_dat_o,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    input wire wp_i
);

    // ****************************************************************
    // States and decode helpers
    // ****************************************************************
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RXB = 5'h02;
    localparam [4:0] S_RACK = 5'h04;
    localparam [4:0] S_TXB = 5'h08;
    localparam [4:0] S_TACK = 5'h10;

    localparam [1:0] K_CTRL = 2'h0;
    localparam [1:0] K_ADDR = 2'h1;
    localparam [1:0] K_DATA = 2'h2;

    // Register select, shared by the read mux and the write path
    function [1:0] reg_sel;
        input [7:0] adr;
        begin
            case (adr)
                `EES_REG_CTRL: reg_sel = 2'h1;
                `EES_REG_STAT: reg_sel = 2'h2;
                `EES_REG_WCNT: reg_sel = 2'h3;
                default: reg_sel = 2'h0;
            endcase
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers and bus condition detection
    // ****************************************************************
    reg scl_s1_ff, scl_s2_ff, scl_old_ff;
    reg sda_s1_ff, sda_s2_ff, sda_old_ff;
    reg wp_s1_ff, wp_s2_ff;

    // Two flops per pin, a third on scl and sda for edges; the first stage feeds no logic
    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_old_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_old_ff <= 1'b1;
            wp_s1_ff <= 1'b0;
            wp_s2_ff <= 1'b0;
        end else begin
            scl_s1_ff <= scl_i;
            scl_s2_ff <= scl_s1_ff;
            scl_old_ff <= scl_s2_ff;
            sda_s1_ff <= sda_i;
            sda_s2_ff <= sda_s1_ff;
            sda_old_ff <= sda_s2_ff;
            wp_s1_ff <= wp_i;
            wp_s2_ff <= wp_s1_ff;
        end
    end

    // Data edges with clock high are framing, never data
    wire scl_rise = scl_s2_ff & ~scl_old_ff;
    wire scl_fall = ~scl_s2_ff & scl_old_ff;
    wire start_det = scl_s2_ff & scl_old_ff & sda_old_ff & ~sda_s2_ff; // [R18]
    wire stop_det = scl_s2_ff & scl_old_ff & ~sda_old_ff & sda_s2_ff; // [R18]

    // ****************************************************************
    // Protocol state
    // ****************************************************************
    reg [4:0] state_ff;
    reg [1:0] kind_ff;
    reg [3:0] cnt_ff;
    reg [7:0] shift_ff;
    reg [7:0] txd_ff;
    reg rw_ff;
    reg [6:0] ptr_ff;
    reg [3:0] page_ff;
    reg pend_ff;
    reg busy_ff;
    reg [19:0] timer_ff;
    reg [7:0] bvalid_ff;
    reg [7:0] buf_ff [0:7];
    reg [7:0] mem [0:127];
    reg commit_ff;
    reg [31:0] ctrl_ff;
    reg [15:0] wcnt_ff;

    wire [7:0] rx_byte = {shift_ff[6:0], sda_s2_ff};
    wire protect = wp_s2_ff | ctrl_ff[`EES_CTRL_SWP];
    wire [2:0] idx = ptr_ff[2:0];

    // Main bus engine: framing first, then bit events by state
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= S_IDLE;
            kind_ff <= K_CTRL;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            txd_ff <= 8'h00;
            rw_ff <= 1'b0;
            ptr_ff <= 7'h00;
            page_ff <= 4'h0;
            pend_ff <= 1'b0;
            busy_ff <= 1'b0;
            timer_ff <= 20'h00000;
            bvalid_ff <= 8'h00;
            commit_ff <= 1'b0;
            wcnt_ff <= 16'h0000;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            commit_ff <= 1'b0;
            // Internal write timer; acknowledges resume when it expires
            if (busy_ff) begin
                if (timer_ff == 20'h00001) begin
                    busy_ff <= 1'b0; // [R19]
                end
                timer_ff <= timer_ff - 20'h00001;
            end
            if (start_det) begin
                // Repeated Start drops buffered data, pointer stays set
                state_ff <= S_RXB;
                kind_ff <= K_CTRL;
                cnt_ff <= 4'h0;
                sda_oe_o <= 1'b0;
                pend_ff <= 1'b0; // [R14]
                bvalid_ff <= 8'h00; // [R14]
            end else if (stop_det) begin
                state_ff <= S_IDLE;
                sda_oe_o <= 1'b0;
                pend_ff <= 1'b0;
                bvalid_ff <= 8'h00;
                // Protected array takes no write and starts no cycle
                if (pend_ff && !protect) begin
                    commit_ff <= 1'b1; // [R6] [R11]
                    busy_ff <= 1'b1; // [R6]
                    timer_ff <= TWC_CYCLES; // [R19]
                    wcnt_ff <= wcnt_ff + 16'h0001;
                end
            end else begin
                case (state_ff)
                    S_IDLE: begin
                        // Released line, waiting for the next Start
                        sda_oe_o <= 1'b0; // [R22]
                    end
                    S_RXB: begin
                        if (scl_rise) begin
                            shift_ff <= rx_byte;
                            cnt_ff <= cnt_ff + 4'h1;
                            if (cnt_ff == 4'h7) begin
                                state_ff <= S_RACK;
                                case (kind_ff)
                                    K_CTRL: begin
                                        // Block-select bits 3..1 never looked at
                                        if (rx_byte[`EES_CTRL_HI:`EES_CTRL_LO] != `EES_DEV_CODE
                                            || busy_ff) begin // [R1] [R2] [R7]
                                            state_ff <= S_IDLE; // [R22] [R7]
                                        end
                                        rw_ff <= rx_byte[`EES_RW_BIT]; // [R3]
                                    end
                                    K_ADDR: begin
                                        // Top word-address bit is dropped
                                        ptr_ff <= rx_byte[6:0]; // [R5] [R21]
                                        page_ff <= rx_byte[6:3];
                                        kind_ff <= K_DATA;
                                    end
                                    default: begin
                                        // Ninth byte lands on the first slot again
                                        buf_ff[idx] <= rx_byte; // [R8] [R9]
                                        bvalid_ff[idx] <= 1'b1; // [R8]
                                        ptr_ff <= {ptr_ff[6:3], idx + 3'h1}; // [R9] [R16]
                                        pend_ff <= 1'b1; // [R8]
                                    end
                                endcase
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_fall) begin
                            if (cnt_ff == 4'h8) begin
                                sda_oe_o <= 1'b1; // [R4] [R5] [R17]
                                cnt_ff <= 4'h9;
                            end else begin
                                sda_oe_o <= 1'b0;
                                cnt_ff <= 4'h0;
                                if (kind_ff == K_CTRL && rw_ff) begin
                                    // Read: first bit goes out on this low phase
                                    txd_ff <= mem[ptr_ff]; // [R12] [R13]
                                    sda_oe_o <= ~mem[ptr_ff][7]; // [R13] [R17]
                                    state_ff <= S_TXB;
                                end else begin
                                    if (kind_ff == K_CTRL) begin
                                        kind_ff <= K_ADDR; // [R5]
                                    end
                                    state_ff <= S_RXB;
                                end
                            end
                        end
                    end
                    S_TXB: begin
                        if (scl_rise) begin
                            cnt_ff <= cnt_ff + 4'h1;
                            if (cnt_ff == 4'h7) begin
                                ptr_ff <= ptr_ff + 7'h01; // [R16] [R21] [R12]
                                state_ff <= S_TACK;
                            end
                        end else if (scl_fall && cnt_ff != 4'h0) begin
                            txd_ff <= {txd_ff[6:0], 1'b0};
                            sda_oe_o <= ~txd_ff[6]; // [R17]
                        end
                    end
                    S_TACK: begin
                        if (scl_fall && cnt_ff == 4'h8) begin
                            sda_oe_o <= 1'b0; // [R20]
                            cnt_ff <= 4'h9;
                        end else if (scl_rise && cnt_ff == 4'h9) begin
                            if (sda_s2_ff) begin
                                state_ff <= S_IDLE; // [R20] [R13]
                            end else begin
                                cnt_ff <= 4'ha; // [R15]
                            end
                        end else if (scl_fall && cnt_ff == 4'ha) begin
                            txd_ff <= mem[ptr_ff]; // [R15]
                            sda_oe_o <= ~mem[ptr_ff][7]; // [R15] [R17]
                            cnt_ff <= 4'h0;
                            state_ff <= S_TXB;
                        end
                    end
                    default: begin
                        state_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Array commit
    // ****************************************************************
    // Snapshot of page and valid bits, taken as the Stop is seen
    reg [7:0] bvalid_q;
    reg [3:0] page_q;
    wire [7:0] slot_we;
    integer s;

    // One write enable per buffered slot
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_commit
            assign slot_we[g] = commit_ff & bvalid_q[g]; // [R6] [R8]
        end
    endgenerate

    // Page copy in one cycle; the timer models the slow array write.
    // A single process owns the array, so it keeps one driver.
    always @(posedge clk_i) begin
        for (s = 0; s < 8; s = s + 1) begin
            if (slot_we[s]) begin
                mem[{page_q, s[2:0]}] <= buf_ff[s]; // [R9]
            end
        end
    end

    // Snapshot update
    always @(posedge clk_i) begin
        if (rst_i) begin
            bvalid_q <= 8'h00;
            page_q <= 4'h0;
        end else if (stop_det) begin
            bvalid_q <= bvalid_ff;
            page_q <= page_ff;
        end
    end

    // ****************************************************************
    // Wishbone classic slave
    // ****************************************************************
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire [1:0] sel_now = reg_sel(wb_adr_i);

    // Ack one cycle after the request; a write lands on the ack edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_ff <= `EES_CTRL_RST;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                case (sel_now)
                    2'h1: wb_dat_o <= ctrl_ff;
                    2'h2: wb_dat_o <= {17'h00000, ptr_ff, 4'h0,
                                       protect, state_ff != S_IDLE, pend_ff, busy_ff};
                    2'h3: wb_dat_o <= {16'h0000, wcnt_ff};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
            if (wb_req && wb_ack_o && wb_we_i && sel_now == 2'h1 && wb_sel_i[0]) begin
                ctrl_ff <= {31'h00000000, wb_dat_i[`EES_CTRL_SWP]}; // [R11]
            end
        end
    end

endmodule // ees_i2c_slave
`default_nettype wire

// [core/ees_i2c_slave_dummy_guard.v]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [bench/ees_i2c_master.sv]
// Two-wire bus master model driving the slave's link pins.
// Assumes sda_i is the resolved wire, pulled high when nobody drives.
`timescale 1ns/10ps
`default_nettype none
module ees_i2c_master #(
    parameter int LO = 3,
    parameter int HI = 4
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // ****************************************
    // Bus idle: both lines released high
    // ****************************************
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Low phase LO+1 clocks, high phase HI clocks: an 80 ns bit.
    // The slave turns the line three clocks after a fall, one before the rise.
    task automatic bit_x(input logic b, output logic r);
        sda_oe_o <= ~b;
        tick(LO);
        scl_o <= 1'b1;
        tick(HI / 2);
        r = sda_i;
        tick(HI - HI / 2);
        scl_o <= 1'b0;
        tick(1);
    endtask
    // First or repeated Start, ends with the clock low
    task automatic start();
        sda_oe_o <= 1'b0;
        tick(LO);
        scl_o <= 1'b1;
        tick(HI);
        sda_oe_o <= 1'b1;
        tick(HI);
        scl_o <= 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        tick(LO);
        scl_o <= 1'b1;
        tick(HI);
        sda_oe_o <= 1'b0;
        tick(HI);
    endtask
    // Bytes go out most significant bit first; slave answers on the ninth
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~mack, r);
    endtask
endmodule // ees_i2c_master
`default_nettype wire

// [bench/ees_i2c_slave_properties.sv]
// Checker on the slave's ports; bound from the bench top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ees_i2c_slave_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic wp_i
);
    // ****************************************
    // Register port and link pin relations
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (wb_ack_o && wb_adr_i == 8'h0c |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_data_low_clk: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("data line moved while clock high");
    a_line_value: assert property (sda_oe_o |-> !sda_o)
        else $error("driven level not low");
    a_wp_status: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04
        && $past(wp_i, 4) && wp_i |-> wb_dat_o[3]) else $error("protect not shown");
    a_start_release: assert property ($fell(sda_i) && scl_i && $past(scl_i)
        |-> !sda_oe_o && !$past(sda_oe_o)) else $error("slave drove during start");
endmodule // ees_i2c_slave_properties
`default_nettype wire

// [bench/tb_ees_i2c_slave.sv]
// Self-checking bench: master model on the link, Wishbone tasks, memory model.
// Assumes the slave resolves sda outside; the wire is pulled up here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_ees_i2c_slave;
    localparam int TWC = 2000;
    localparam logic [3:0] DEV = 4'h6; // Arbitrary device-type code, as in the slave
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wp = 0, k;
    logic [7:0] adr = 0, d;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, q, seed = 32'hecb48038;
    logic wb_ack_o, sda_o, sda_oe_o, scl, m_oe;
    logic [31:0] wb_dat_o;
    int n_errors = 0, n_tests = 0, cyc_cnt = 0, ptr = 0, n_wr = 0;
    int mem[128];
    wire logic sda_w = ~(m_oe | sda_oe_o);
    // ****************************************
    // Clock, parts and timeout
    // ****************************************
    always #5 clk_i = ~clk_i;
    ees_i2c_slave #(.TWC_CYCLES(20'(TWC))) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp));
    ees_i2c_master mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));
    // Hang guard sized above the whole sequence
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 95000) begin
            n_errors++;
            end_of_test;
        end
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Classic cycle: request held until ack is sampled high; only the
    // bench timeout ends a wait that never gets its answer
    task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= v; sel <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Write n bytes from a, then check busy and polling
    task wr(input int a, input int n, input logic prot);
        logic [31:0] x;
        x = rnd();
        mst.start();
        mst.wbyte({DEV, x[2:0], 1'b0}, k); `CHK("ctrl ack", 1'b1, k)
        mst.wbyte(8'(a), k); `CHK("addr ack", 1'b1, k)
        for (int i = 0; i < n; i++) begin
            d = rnd() >> 8;
            mst.wbyte(d, k); `CHK("data ack", 1'b1, k)
            if (!prot) mem[(a & 'h78) | ((a + i) & 7)] = d;
        end
        mst.stop();
        if (!prot) n_wr++;
        wb(1'b0, 8'h04, 0); `CHK("busy", ~prot, q[0])
        mst.start();
        mst.wbyte({DEV, 4'h0}, k); `CHK("poll", prot, k)
        mst.stop();
        repeat (TWC) @(posedge clk_i);
        wb(1'b0, 8'h04, 0); `CHK("idle", 1'b0, q[0])
    endtask
    // Random read from a, or current read when a is negative
    task rd(input int a, input int n);
        if (a >= 0) begin
            mst.start();
            mst.wbyte({DEV, 4'h0}, k);
            mst.wbyte(8'(a), k);
            ptr = a & 'h7f;
        end
        mst.start();
        mst.wbyte({DEV, 4'h1}, k); `CHK("rd ack", 1'b1, k)
        for (int i = 0; i < n; i++) begin
            mst.rbyte(i < n - 1, d);
            if (mem[ptr] >= 0) `CHK("rd data", 8'(mem[ptr]), d)
            ptr = (ptr + 1) & 'h7f;
        end
        mst.stop();
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        foreach (mem[i]) mem[i] = -1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1'b0, 8'h00, 0); `CHK("ctrl rst", 32'h0, q)
        wb(1'b1, 8'h00, 1); wb(1'b0, 8'h00, 0); `CHK("ctrl wr", 32'h1, q)
        wb(1'b1, 8'h00, 0); wb(1'b0, 8'h0c, 0); `CHK("unmapped", 32'h0, q)
        $display("registers done");
        wr('h13, 9, 1'b0);
        rd('h10, 8);
        $display("page wrap done");
        wr('h00, 2, 1'b0);
        wr('hff, 1, 1'b0);
        rd('hff, 2);
        rd(-1, 1);
        wb(1'b0, 8'h04, 0); `CHK("ptr", 7'(ptr), q[14:8])
        $display("sequential and current read done");
        wp <= 1'b1;
        wr('h00, 1, 1'b1);
        wp <= 1'b0;
        rd('h00, 1);
        $display("write protect done");
        mst.start();
        mst.wbyte(8'hb0, k); `CHK("foreign", 1'b0, k)
        mst.wbyte(8'h00, k); `CHK("ignored", 1'b0, k)
        mst.stop();
        $display("foreign code done");
        wb(1'b0, 8'h08, 0); `CHK("wcnt", 32'(n_wr), q)
        end_of_test;
    end
endmodule // tb_ees_i2c_slave
bind ees_i2c_slave ees_i2c_slave_properties u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i));
`default_nettype wire
